// >>> verilog/tsense_pkg.sv
`default_nettype none
package tsense_pkg;
  // bus clock and millisecond base
  localparam int unsigned CLK_HZ     = 50_000_000;
  localparam int unsigned MS_PER_S   = 1000;
  localparam int unsigned CYC_PER_MS = CLK_HZ / MS_PER_S;
  // register map
  localparam logic [31:0] BASE_ADDR  = 32'h4006_0000;
  localparam logic [7:0]  OFF_CTRL   = 8'h00;
  localparam logic [7:0]  OFF_RESULT = 8'h04;
  localparam logic [7:0]  OFF_STATUS = 8'h08;
  localparam logic [7:0]  OFF_SETUP  = 8'h0c;
  localparam logic [7:0]  OFF_CAL_A  = 8'h10;
  localparam logic [7:0]  OFF_CAL_B  = 8'h14;
  localparam logic [7:0]  OFF_ALPHA  = 8'h18;
  localparam logic [7:0]  OFF_LOW    = 8'h1c;
  localparam logic [7:0]  OFF_HIGH   = 8'h20;
  localparam logic [7:0]  OFF_MASK   = 8'h24;
  localparam logic [7:0]  OFF_RIS    = 8'h28;
  localparam logic [7:0]  OFF_MIS    = 8'h2c;
  localparam logic [7:0]  OFF_ICLR   = 8'h30;
  // reset values
  localparam logic [15:0] RST_LOW    = 16'h8000;
  localparam logic [15:0] RST_HIGH   = 16'h7fff;
  localparam logic [3:0]  RST_SETUP  = 4'hf;
  localparam logic [15:0] RST_ZERO   = 16'h0000;
  // field positions
  localparam int unsigned START_BIT  = 0;
  localparam int unsigned FMT_BIT    = 0;
  localparam int unsigned RES_LSB    = 1;
  localparam int unsigned OK_BIT     = 4;
  localparam int unsigned SRES_LSB   = 5;
  localparam int unsigned SFMT_BIT   = 8;
  localparam int unsigned IRQ_LOW    = 0;
  localparam int unsigned IRQ_HIGH   = 1;
  // conversion time in ms per resolution code
  localparam logic [6:0]  CONV_MS_7  = 7'h04;
  localparam logic [6:0]  CONV_MS_8  = 7'h07;
  localparam logic [6:0]  CONV_MS_9  = 7'h0e;
  localparam logic [6:0]  CONV_MS_10 = 7'h1a;
  localparam logic [6:0]  CONV_MS_11 = 7'h32;
  localparam logic [6:0]  CONV_MS_12 = 7'h64;
  // restoring divider length: width of the dividend
  localparam logic [5:0]  DIV_STEPS  = 6'h21;

  typedef struct packed {
    logic [3:0]  range;
    logic [15:0] raw;
  } sens_sample_t;
endpackage : tsense_pkg
`default_nettype wire

// >>> verilog/die_temp_ctrl.sv
//Contract
// - start bit launches one conversion, self-clears
// - conversion time follows selected resolution
// - calibrated T = A*alpha/(alpha+X) + B
// - result low 16 bits, raw or calibrated
// - reading result clears pending interrupts
// - calibrated output is in Kelvin
// - thirteen word registers at fixed base
// - thresholds reset to 0x8000 and 0x7fff
// - masked status is raw status and mask
// - clear register write-only, clears written bits
// - setup register resets to 0xf
// - A, B, alpha registers, reset zero, used
// - reserved bits not guaranteed, read zero here
// - setup bit0 format, bits 3:1 resolution
// - below low or above high raises interrupt; here only calibrated results are compared, raw never raises one
// - status: ok bit4, range bits, echoes
//
// Added by the designer: the APB register port.
`timescale 1ns/1ps
`default_nettype none
module die_temp_ctrl #(
  parameter int unsigned MS_CYCLES = tsense_pkg::CYC_PER_MS
) (
  // clock and reset
  input  wire logic                     mclk,
  input  wire logic                     rst_n,
  // apb slave
  input  wire logic                     psel,
  input  wire logic                     penable,
  input  wire logic                     pwrite,
  input  wire logic [31:0]              paddr,
  input  wire logic [31:0]              pwdata,
  output logic                          pready,
  output logic [31:0]                   prdata,
  output logic                          pslverr,
  // sensor front end
  input  wire tsense_pkg::sens_sample_t sens_in,
  output logic                          sens_en,
  output logic [2:0]                    sens_res
);
  import tsense_pkg::*;

  typedef enum {ST_IDLE, ST_CONV, ST_CALC} conv_state_t;

  function automatic logic addr_hit(input logic [31:0] a);
    addr_hit = (a[31:8] == BASE_ADDR[31:8]) && (a[1:0] == 2'h0) && (a[7:0] <= OFF_ICLR);
  endfunction : addr_hit

  function automatic logic [6:0] conv_ms(input logic [2:0] res);
    case (res)
      3'h2:    conv_ms = CONV_MS_7;
      3'h3:    conv_ms = CONV_MS_8;
      3'h4:    conv_ms = CONV_MS_9;
      3'h5:    conv_ms = CONV_MS_10;
      3'h6:    conv_ms = CONV_MS_11;
      default: conv_ms = CONV_MS_12;
    endcase
  endfunction : conv_ms

  conv_state_t  state_r;
  logic         start_r;
  logic [15:0]  result_r;
  logic [8:0]   status_r;
  logic [3:0]   setup_r;
  logic [15:0]  cal_a_r;
  logic [15:0]  cal_b_r;
  logic [15:0]  alpha_r;
  logic [15:0]  low_r;
  logic [15:0]  high_r;
  logic [1:0]   mask_r;
  logic [1:0]   ris_r;
  logic         fmt_used_r;
  logic [2:0]   res_used_r;
  logic [31:0]  ms_div_r;
  logic [6:0]   ms_cnt_r;
  logic [5:0]   step_r;
  logic [32:0]  dvd_r;
  logic [18:0]  rem_r;
  logic [17:0]  dsr_r;
  sens_sample_t smp_r;
  sens_sample_t sync1_r;
  sens_sample_t sync2_r;
  logic         pready_r;
  logic [31:0]  prdata_r;
  logic         pslverr_r;
  logic         sens_en_r;
  logic [2:0]   sens_res_r;

  // apb decode
  logic        setup_ph;
  logic        access;
  logic        hit;
  logic        wr;
  logic        rd_result;
  logic [7:0]  off;
  assign setup_ph  = psel && !penable;
  assign access    = psel && penable && pready_r;
  assign hit       = addr_hit(paddr);
  assign off       = paddr[7:0];
  assign wr        = access && pwrite && hit;
  assign rd_result = access && !pwrite && hit && (off == OFF_RESULT);

  // conversion timing and divider datapath
  logic        ms_tick;
  logic        conv_end;
  logic        finish;
  logic [18:0] trial;
  logic        sub_ok;
  logic [15:0] cal_val;
  logic [15:0] res_val;
  logic [1:0]  irq_ev;
  sens_sample_t fin_smp;
  assign ms_tick  = (state_r == ST_CONV) && (ms_div_r == 32'(MS_CYCLES - 1));
  assign conv_end = ms_tick && (ms_cnt_r == conv_ms(res_used_r) - 7'h01);
  assign finish   = (conv_end && !fmt_used_r) ||
                    ((state_r == ST_CALC) && (step_r == DIV_STEPS - 6'h01));
  assign trial    = {rem_r[17:0], dvd_r[32]};
  assign sub_ok   = trial >= {1'b0, dsr_r};
  // quotient has 6 fractional bits, matching A; B adds the offset to Kelvin
  assign cal_val  = {dvd_r[14:0], sub_ok} + cal_b_r;
  // raw completion lands in the conversion state, before the sample flop has loaded
  assign fin_smp  = (state_r == ST_CONV) ? sync2_r : smp_r;
  assign res_val  = fmt_used_r ? cal_val : fin_smp.raw;
  assign irq_ev[IRQ_LOW]  = fmt_used_r && ($signed(cal_val) < $signed(low_r));
  assign irq_ev[IRQ_HIGH] = fmt_used_r && ($signed(cal_val) > $signed(high_r));

  // two flops on the asynchronous front end sample
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      sync1_r <= '0;
      sync2_r <= '0;
    end else begin
      sync1_r <= sens_in;
      sync2_r <= sync1_r;
    end
  end

  // conversion sequencer
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      state_r    <= ST_IDLE;
      start_r    <= 1'b0;
      fmt_used_r <= 1'b0;
      res_used_r <= 3'h0;
      ms_div_r   <= 32'h0;
      ms_cnt_r   <= 7'h0;
      smp_r      <= '0;
    end else begin
      case (state_r)
        ST_IDLE: begin
          if (wr && off == OFF_CTRL && pwdata[START_BIT]) begin
            state_r    <= ST_CONV;
            start_r    <= 1'b1;
            fmt_used_r <= setup_r[FMT_BIT];
            res_used_r <= setup_r[RES_LSB +: 3];
            ms_div_r   <= 32'h0;
            ms_cnt_r   <= 7'h0;
          end
        end
        ST_CONV: begin
          // writes to the start bit land here and are dropped
          ms_div_r <= ms_tick ? 32'h0 : ms_div_r + 32'h1;
          if (ms_tick) begin
            ms_cnt_r <= ms_cnt_r + 7'h01;
          end
          if (conv_end) begin
            smp_r   <= sync2_r;
            state_r <= fmt_used_r ? ST_CALC : ST_IDLE;
            start_r <= fmt_used_r;
          end
        end
        ST_CALC: begin
          if (finish) begin
            state_r <= ST_IDLE;
            start_r <= 1'b0;
          end
        end
        default: begin
          state_r <= ST_IDLE;
          start_r <= 1'b0;
        end
      endcase
    end
  end

  // restoring divider: (A * alpha) / (alpha + X), alpha widened to 11 fraction bits
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      step_r <= 6'h0;
      dvd_r  <= 33'h0;
      rem_r  <= 19'h0;
      dsr_r  <= 18'h0;
    end else if (state_r == ST_CONV && conv_end) begin
      step_r <= 6'h0;
      dvd_r  <= cal_a_r * {alpha_r, 1'b0};
      rem_r  <= 19'h0;
      dsr_r  <= {1'b0, alpha_r, 1'b0} + {2'h0, sync2_r.raw};
    end else if (state_r == ST_CALC) begin
      step_r <= step_r + 6'h01;
      dvd_r  <= {dvd_r[31:0], sub_ok};
      rem_r  <= sub_ok ? trial - {1'b0, dsr_r} : trial;
    end
  end

  // result and status, written together at completion
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      result_r <= RST_ZERO;
      status_r <= 9'h0;
    end else if (finish) begin
      result_r <= res_val;
      status_r[3:0]                <= fin_smp.range;
      status_r[OK_BIT]             <= ~|fin_smp.range;
      status_r[SRES_LSB +: 3]      <= res_used_r;
      status_r[SFMT_BIT]           <= fmt_used_r;
    end
  end

  // software registers
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      setup_r <= RST_SETUP;
      cal_a_r <= RST_ZERO;
      cal_b_r <= RST_ZERO;
      alpha_r <= RST_ZERO;
      low_r   <= RST_LOW;
      high_r  <= RST_HIGH;
      mask_r  <= 2'h0;
    end else if (wr) begin
      case (off)
        OFF_SETUP: setup_r <= pwdata[3:0];
        OFF_CAL_A: cal_a_r <= pwdata[15:0];
        OFF_CAL_B: cal_b_r <= pwdata[15:0];
        OFF_ALPHA: alpha_r <= pwdata[15:0];
        OFF_LOW:   low_r   <= pwdata[15:0];
        OFF_HIGH:  high_r  <= pwdata[15:0];
        OFF_MASK:  mask_r  <= pwdata[1:0];
        default:   ;
      endcase
    end
  end

  // raw interrupt status: a new event wins over any clear in the same cycle
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      ris_r <= 2'h0;
    end else begin
      ris_r <= (ris_r & ~(rd_result ? 2'h3 : 2'h0)
                      & ~((wr && off == OFF_ICLR) ? pwdata[1:0] : 2'h0))
               | (finish ? irq_ev : 2'h0);
    end
  end

  // apb answer: one wait-free access phase, reads captured in setup
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      pready_r  <= 1'b0;
      prdata_r  <= 32'h0;
      pslverr_r <= 1'b0;
    end else begin
      pready_r  <= setup_ph;
      pslverr_r <= setup_ph && !hit;
      if (setup_ph) begin
        // reserved and write-only locations read as zero
        case (hit ? off : 8'hff)
          OFF_CTRL:   prdata_r <= {31'h0, start_r};
          OFF_RESULT: prdata_r <= {16'h0, result_r};
          OFF_STATUS: prdata_r <= {23'h0, status_r};
          OFF_SETUP:  prdata_r <= {28'h0, setup_r};
          OFF_CAL_A:  prdata_r <= {16'h0, cal_a_r};
          OFF_CAL_B:  prdata_r <= {16'h0, cal_b_r};
          OFF_ALPHA:  prdata_r <= {16'h0, alpha_r};
          OFF_LOW:    prdata_r <= {16'h0, low_r};
          OFF_HIGH:   prdata_r <= {16'h0, high_r};
          OFF_MASK:   prdata_r <= {30'h0, mask_r};
          OFF_RIS:    prdata_r <= {30'h0, ris_r};
          OFF_MIS:    prdata_r <= {30'h0, ris_r & mask_r};
          default:    prdata_r <= 32'h0;
        endcase
      end
    end
  end

  // front end control
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      sens_en_r  <= 1'b0;
      sens_res_r <= 3'h0;
    end else begin
      sens_en_r  <= (state_r == ST_CONV) && !conv_end;
      sens_res_r <= res_used_r;
    end
  end

  assign pready   = pready_r;
  assign prdata   = prdata_r;
  assign pslverr  = pslverr_r;
  assign sens_en  = sens_en_r;
  assign sens_res = sens_res_r;

  // checking helpers
  logic [31:0] conv_cyc_r;
  always_ff @(posedge mclk) begin
    if (!rst_n || state_r != ST_CONV) begin
      conv_cyc_r <= 32'h0;
    end else begin
      conv_cyc_r <= conv_cyc_r + 32'h1;
    end
  end
  logic [32:0] ref_quo;
  assign ref_quo = (dsr_r == 18'h0) ? {33{1'b1}} : (cal_a_r * {alpha_r, 1'b0}) / dsr_r;

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);

  a_start_busy_link: assert property ((state_r != ST_IDLE) == start_r)
    else $error("start bit does not track a running conversion");
  a_conv_time_len: assert property ((state_r == ST_CONV && conv_end) |->
    (conv_cyc_r + 32'h1 == 32'(conv_ms(res_used_r)) * 32'(MS_CYCLES)))
    else $error("conversion length wrong for resolution");
  a_calib_value_ok: assert property ((state_r == ST_CALC && finish) |=>
    result_r == $past(ref_quo[15:0] + cal_b_r))
    else $error("calibrated result mismatch");
  a_result_hold_stable: assert property (!finish |=> $stable(result_r))
    else $error("result changed outside completion");
  a_read_clears_irq: assert property ((rd_result && !finish) |=> ris_r == 2'h0)
    else $error("result read did not clear interrupts");
  a_masked_status_read: assert property ((setup_ph && hit && off == OFF_MIS) |=>
    prdata_r[1:0] == ($past(ris_r) & $past(mask_r)))
    else $error("masked status wrong");
  a_clear_reg_write: assert property ((wr && off == OFF_ICLR && !finish) |=>
    (ris_r & $past(pwdata[1:0])) == 2'h0)
    else $error("clear write left bit set");
  a_reset_values_ok: assert property (!$past(rst_n) |->
    low_r == RST_LOW && high_r == RST_HIGH && setup_r == RST_SETUP)
    else $error("register reset value wrong");
  a_high_irq_raise: assert property ((finish && irq_ev[IRQ_HIGH]) |=> ris_r[IRQ_HIGH])
    else $error("high threshold event lost");
  a_done_same_cycle: assert property ($fell(start_r) |->
    $past(finish) && status_r[SFMT_BIT] == $past(fmt_used_r))
    else $error("completion not aligned with start clear");
  a_ignore_restart: assert property ((state_r == ST_CONV && wr && off == OFF_CTRL && !conv_end)
    |=> state_r == ST_CONV && $stable(res_used_r))
    else $error("start write disturbed running conversion");
  a_apb_ready_timing: assert property (setup_ph |=> pready_r)
    else $error("access phase not ready after setup");
  a_slave_error_map: assert property ((setup_ph && !hit) |=>
    pslverr_r && prdata_r == 32'h0)
    else $error("unmapped access not flagged");
  a_reserved_reads_zero: assert property ((setup_ph && hit && off == OFF_CTRL) |=>
    prdata_r[31:1] == 31'h0)
    else $error("reserved control bits not zero");
  a_calib_regs_reset: assert property (!$past(rst_n) |->
    cal_a_r == RST_ZERO && cal_b_r == RST_ZERO && alpha_r == RST_ZERO)
    else $error("calibration register reset value wrong");
  a_setup_latched_start: assert property (
    (state_r == ST_IDLE && wr && off == OFF_CTRL && pwdata[START_BIT]) |=>
    res_used_r == $past(setup_r[RES_LSB +: 3]) && fmt_used_r == $past(setup_r[FMT_BIT]))
    else $error("conversion did not take the setup fields");
  a_status_echo_fields: assert property (finish |=>
    status_r[SRES_LSB +: 3] == $past(res_used_r) && status_r[OK_BIT] == !(|status_r[3:0]))
    else $error("status echo fields wrong");
  a_raw_result_value: assert property ((finish && !fmt_used_r) |=>
    result_r == $past(sync2_r.raw))
    else $error("raw result is not the sample at conversion end");
  a_raw_range_flags: assert property ((finish && !fmt_used_r) |=>
    status_r[3:0] == $past(sync2_r.range))
    else $error("range flags are not the sample at conversion end");
  a_low_irq_raise: assert property ((finish && irq_ev[IRQ_LOW]) |=> ris_r[IRQ_LOW])
    else $error("low threshold event lost");
  a_sens_enable_busy: assert property (sens_en_r |-> state_r == ST_CONV)
    else $error("front end enabled outside a conversion");
endmodule : die_temp_ctrl
`default_nettype wire

// >>> tb/die_temp_ctrl_tb.sv
`timescale 1ns/1ps
`default_nettype none
module die_temp_ctrl_tb;
  import tsense_pkg::*;
  // short millisecond so a 100 ms conversion stays cheap
  localparam int unsigned MS = 10;
  logic         mclk, rst_n, psel, penable, pwrite, pready, pslverr, sens_en, err;
  logic [31:0]  paddr, pwdata, prdata, rd, wd;
  logic [2:0]   sens_res;
  logic [15:0]  x;
  sens_sample_t sens_in;
  int           error_cnt, compares, cyc, seed;

  die_temp_ctrl #(.MS_CYCLES(MS)) u_dut (
    .mclk(mclk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata),
    .pslverr(pslverr), .sens_in(sens_in), .sens_en(sens_en), .sens_res(sens_res));

  initial begin
    mclk = 1'b0;
    forever #10 mclk = ~mclk;
  end
  always @(posedge mclk) cyc <= cyc + 1;

  task complete_run;
    $display("checks %0d mismatches %0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : complete_run

  task check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      $display("[FAIL] %s expected %h seen %h", name, exp, seen);
      error_cnt++;
    end
  endtask : check

  // one apb transfer; request held until pready is sampled high
  task apb(input logic w, input logic [7:0] off, input logic [31:0] d,
           output logic [31:0] r, output logic e);
    int n;
    @(posedge mclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= BASE_ADDR | {24'h0, off};
    pwdata  <= d;
    @(posedge mclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge mclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) begin
      error_cnt++;
      complete_run();
    end
    r = prdata;
    e = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task wr(input logic [7:0] off, input logic [31:0] d);
    apb(1'b1, off, d, rd, err);
  endtask : wr

  task rdchk(input string name, input logic [7:0] off, input logic [31:0] exp);
    apb(1'b0, off, 32'h0, rd, err);
    check(name, rd, exp);
    check("no slave error", {31'h0, err}, 32'h0);
  endtask : rdchk

  function automatic int conv_ms(input logic [2:0] c);
    case (c)
      3'h2: return 4;
      3'h3: return 7;
      3'h4: return 14;
      3'h5: return 26;
      3'h6: return 50;
      default: return 100;
    endcase
  endfunction : conv_ms

  function automatic logic [15:0] calc(input logic [15:0] a, b, al, xv);
    logic [32:0] num;
    logic [17:0] den;
    logic [32:0] q;
    num = {17'h0, a} * {16'h0, al, 1'b0};
    den = {1'b0, al, 1'b0} + {2'h0, xv};
    q   = (den == 18'h0) ? {33{1'b1}} : num / {15'h0, den};
    return q[15:0] + b;
  endfunction : calc

  function automatic logic [31:0] rstv(input int i);
    case (i)
      3: return {28'h0, RST_SETUP};
      7: return {16'h0, RST_LOW};
      8: return {16'h0, RST_HIGH};
      default: return 32'h0;
    endcase
  endfunction : rstv

  // one measurement; extra covers the calibration divide
  task conv(input logic [3:0] setup, input logic [15:0] xv, input logic [3:0] rng,
            input int extra);
    int n, lim, el;
    lim = conv_ms(setup[3:1]) * MS + extra;
    wr(OFF_SETUP, {28'h0, setup});
    sens_in <= {rng, xv};
    wr(OFF_CTRL, 32'h1);
    n = cyc;
    rdchk("start bit", OFF_CTRL, 32'h1);
    wr(OFF_CTRL, 32'h1);
    check("sens_en", {31'h0, sens_en}, 32'h1);
    check("sens_res", {29'h0, sens_res}, {29'h0, setup[3:1]});
    do apb(1'b0, OFF_CTRL, 32'h0, rd, err); while (rd[0] === 1'b1 && cyc - n < lim + 60);
    if (rd[0] !== 1'b0) begin
      error_cnt++;
      complete_run();
    end
    el = cyc - n;
    check("sens_en idle", {31'h0, sens_en}, 32'h0);
    check("conv time", {31'h0, el >= lim && el <= lim + 6}, 32'h1);
    rdchk("status", OFF_STATUS, {23'h0, setup[0], setup[3:1], rng == 4'h0, rng});
  endtask : conv

  initial begin
    seed = 26;
    rst_n = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 32'h0;
    pwdata = 32'h0;
    sens_in = '0;
    repeat (10) @(posedge mclk);
    rst_n <= 1'b1;
    for (int i = 0; i < 12; i++) rdchk("reset value", 8'(i * 4), rstv(i));
    $display("test reset values done");
    for (int i = 3; i < 10; i++) begin
      wd = $random(seed);
      wr(8'(i * 4), wd);
      rdchk("readback", 8'(i * 4), wd & (i == 3 ? 32'hf : i == 9 ? 32'h3 : 32'hffff));
    end
    wr(OFF_STATUS, 32'hffffffff);
    rdchk("read-only status", OFF_STATUS, 32'h0);
    apb(1'b0, 8'h34, 32'h0, rd, err);
    check("unmapped error", {31'h0, err}, 32'h1);
    wr(OFF_ICLR, 32'h3);
    $display("test register access done");
    // thresholds that would fire in calibrated mode must stay quiet in raw mode
    wr(OFF_LOW, 32'h7fff);
    wr(OFF_HIGH, 32'h8000);
    wr(OFF_MASK, 32'h3);
    for (int c = 2; c < 8; c++) begin
      x = 16'($random(seed));
      conv({c[2:0], 1'b0}, x, c == 4 ? 4'h5 : 4'h0, 0);
      rdchk("raw result", OFF_RESULT, {16'h0, x});
      rdchk("raw no irq", OFF_RIS, 32'h0);
    end
    $display("test raw conversions done");
    wr(OFF_CAL_A, 32'h4000);
    wr(OFF_CAL_B, 32'h1000);
    wr(OFF_ALPHA, 32'h0400);
    wr(OFF_HIGH, 32'h7fff);
    wr(OFF_MASK, 32'h1);
    x = 16'($random(seed));
    conv(4'h5, x, 4'h0, 33);
    rdchk("low irq raw", OFF_RIS, 32'h1);
    rdchk("low irq masked", OFF_MIS, 32'h1);
    rdchk("cal result", OFF_RESULT, {16'h0, calc(16'h4000, 16'h1000, 16'h0400, x)});
    rdchk("read clears irq", OFF_RIS, 32'h0);
    $display("test low threshold done");
    wr(OFF_LOW, 32'h8000);
    wr(OFF_HIGH, 32'h0000);
    wr(OFF_MASK, 32'h0);
    x = 16'($random(seed));
    conv(4'h7, x, 4'h0, 33);
    rdchk("high irq raw", OFF_RIS, 32'h2);
    rdchk("high irq masked off", OFF_MIS, 32'h0);
    wr(OFF_ICLR, 32'h2);
    rdchk("clear register", OFF_RIS, 32'h0);
    rdchk("cal result", OFF_RESULT, {16'h0, calc(16'h4000, 16'h1000, 16'h0400, x)});
    $display("test high threshold done");
    complete_run();
  end
endmodule : die_temp_ctrl_tb
`default_nettype wire
